/* File: cfs_pkg.sv */
// Constants for the current-sense filter readout block.
// Assumes 16-bit registers addressed by a 12-bit word address.
`default_nettype none

package cfs_pkg;

  // ==========================================================
  // Register map
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 16;
  localparam int          NUM_CUR         = 5;
  localparam logic [11:0] A_LV4_SINC      = 12'h313;
  localparam logic [11:0] A_LV4_IIR       = 12'h317;
  localparam logic [11:0] A_LV4_RMS       = 12'h31b;
  localparam logic [11:0] A_LV3_FINAL     = 12'h31e;
  localparam logic [11:0] A_LV4_FINAL     = 12'h31f;
  localparam logic [11:0] A_CUR_CFG_BASE  = 12'h321;
  localparam logic [11:0] A_CUR_SINC_BASE = 12'h331;
  localparam logic [11:0] A_CUR_IIR_BASE  = 12'h336;

  // ==========================================================
  // Configuration fields of each current channel
  localparam int         DECAY_LSB = 0;
  localparam int         DECAY_W   = 4;
  localparam int         GAIN_LSB  = 4;
  localparam int         GAIN_W    = 4;
  localparam int         FBSEL_BIT = 8;
  localparam int         CFG_W     = 9;
  localparam logic [8:0] CFG_SAFE  = 9'h07a;

  // ==========================================================
  // Averager of the LVDT pair
  localparam int         AVG_SHORT     = 8;
  localparam int         AVG_LONG      = 16;
  localparam logic [2:0] AVG_SHORT_LOG = 3'h3;
  localparam logic [2:0] AVG_LONG_LOG  = 3'h4;

  // ==========================================================
  // Sample stream: channel tag and payload
  localparam int TAG_W  = 3;
  localparam int SMP_W  = DATA_W + TAG_W;

endpackage

`default_nettype wire

/* File: cfs_stream_if.sv */
// Valid/ready sample carrier between the readout and its buffer.
// Assumes both ends share one clock.
`default_nettype none

interface cfs_stream_if #(parameter int W = 19);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: cfs_cur_chan.sv */
// One current-sense chain: sinc decimator with gain, then DC-removing
// IIR. Assumes a one-bit modulator stream sampled on every clock.
`default_nettype none

module cfs_cur_chan
  import cfs_pkg::*;
#(
  parameter int DEC_RATIO = 16,
  parameter int ACC_W     = 24
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                bit_in,
  input  wire logic [DECAY_W-1:0]  decay,
  input  wire logic [GAIN_W-1:0]   gain,
  output logic      [DATA_W-1:0]   sinc_q,
  output logic      [DATA_W-1:0]   iir_q,
  output logic                     res_valid_q
);

  // ==========================================================
  // Integrators and decimation count
  logic signed [ACC_W-1:0] int1_q, int2_q, last2_q, diff1_q;
  logic [$clog2(DEC_RATIO)-1:0] dec_cnt_q;
  logic signed [ACC_W-1:0] comb1, comb2, scaled;
  logic signed [ACC_W-1:0] dc_q, diff_dc;
  logic signed [ACC_W-1:0] x_ext;
  logic dump;

  assign dump = (dec_cnt_q == ($clog2(DEC_RATIO))'(DEC_RATIO - 1));

  // Stream of +1/-1 into two integrators
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int1_q    <= '0;
      int2_q    <= '0;
      dec_cnt_q <= '0;
    end else begin
      int1_q    <= int1_q + (bit_in ? ACC_W'(1) : -ACC_W'(1));
      int2_q    <= int2_q + int1_q;
      dec_cnt_q <= dump ? '0 : dec_cnt_q + 1'b1;
    end
  end

  // Two comb stages at the decimated rate, gain as a left shift
  assign comb1  = int2_q - last2_q;
  assign comb2  = comb1 - diff1_q;
  assign scaled = comb2 <<< gain;

  // Saturate a wide value into the 16-bit result
  function automatic logic [DATA_W-1:0] sat16(logic signed [ACC_W-1:0] v);
    if (v > ACC_W'(32767))
      return 16'h7fff;
    else if (v < -ACC_W'(32768))
      return 16'h8000;
    else
      return v[DATA_W-1:0];
  endfunction

  // Decimator result and DC tracker
  assign x_ext   = ACC_W'($signed(sat16(scaled)));
  assign diff_dc = x_ext - dc_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last2_q     <= '0;
      diff1_q     <= '0;
      sinc_q      <= '0;
      iir_q       <= '0;
      dc_q        <= '0;
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= dump;
      if (dump) begin
        last2_q <= int2_q;
        diff1_q <= comb1;
        sinc_q  <= sat16(scaled);
        iir_q   <= sat16(diff_dc);
        dc_q    <= dc_q + (diff_dc >>> decay);
      end
    end
  end

endmodule

`default_nettype wire

/* File: cfs_skid.sv */
// Two-entry buffer between the readout and the sample consumer.
// Assumes the consumer may hold ready low for any length of time.
`default_nettype none

module cfs_skid
  import cfs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  cfs_stream_if.snk in_s,
  cfs_stream_if.src out_s
);

  // ==========================================================
  // Storage, entry 0 is the head
  logic [SMP_W-1:0] ent0_q, ent1_q;
  logic [1:0]       cnt_q;
  logic             push, pop;

  assign in_s.ready  = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data  = ent0_q;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // Shift on pop, fill the first free slot on push
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ent0_q <= '0;
      ent1_q <= '0;
      cnt_q  <= 2'h0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        ent0_q <= (cnt_q == 2'h2) ? ent1_q : in_s.data;
        if (push && cnt_q == 2'h2)
          ent1_q <= in_s.data;
      end else if (push) begin
        if (cnt_q == 2'h0)
          ent0_q <= in_s.data;
        else
          ent1_q <= in_s.data;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A stalled head word stays put
  skid_hold_a: assert property (
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("buffer head changed while stalled");
  // Never more than two entries
  skid_depth_a: assert property (cnt_q <= 2'h2)
    else $error("buffer count above two");

endmodule

`default_nettype wire

/* File: cfs_filter_readout.sv */
// Readout and configuration of the five current-sense filter chains
// and of the LVDT 3/4 result registers, with a sample stream out.
// Assumes a synchronous 16-bit register port and upstream LVDT stages.
//
// Contract
// - Each current channel has a 4-bit IIR decay in bits 3:0, safe 0xA.
// - Each current channel has a 4-bit sinc gain in bits 7:4, safe 7.
// - Channel 1 bit 8 set makes its input the pulse output 5 feedback.
// - Channel 2 bit 8 set makes its input the pulse output 6 feedback.
// - Channel 3 bit 8 set makes its input the pulse output 7 feedback.
// - Channels 4 and 5 take pulse output 8 feedback when bit 8 is set.
// - The 16-bit sinc result of every current channel is readable.
// - The 16-bit IIR result of every current channel and LVDT 4 is readable.
// - The 16-bit final results of LVDT channels 3 and 4 are readable.
// - The 16-bit sinc-n8 result of LVDT channel 4 is readable.
// - The 16-bit RMS result of LVDT channel 4 is readable.
// - The LVDT 3/4 averager spans 8 samples if its length bit is 0, else 16.
`default_nettype none

module cfs_filter_readout
  import cfs_pkg::*;
#(
  parameter int DEC_RATIO = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata,
  output logic                    reg_rvalid,
  // Modulator bitstreams and pulse output feedback
  input  wire logic [NUM_CUR-1:0] sd_bit,
  input  wire logic               pulse_output_five,
  input  wire logic               pulse_output_six,
  input  wire logic               pulse_output_seven,
  input  wire logic               pulse_output_eight,
  // LVDT stage results from upstream
  input  wire logic               lvdt_pair_average_length,
  input  wire logic [DATA_W-1:0]  lvdt_three_final_sample,
  input  wire logic               lvdt_three_final_valid,
  input  wire logic [DATA_W-1:0]  lvdt_four_final_sample,
  input  wire logic               lvdt_four_final_valid,
  input  wire logic [DATA_W-1:0]  lvdt_four_decimator_sample,
  input  wire logic [DATA_W-1:0]  lvdt_four_highpass_sample,
  input  wire logic [DATA_W-1:0]  lvdt_four_rms_sample,
  input  wire logic               lvdt_four_stage_valid,
  // Current-channel sample stream
  output logic                    smp_valid,
  input  wire logic               smp_ready,
  output logic      [DATA_W-1:0]  smp_data,
  output logic      [TAG_W-1:0]   smp_chan
);

  // ==========================================================
  // Configuration registers
  logic [CFG_W-1:0]  cfg_q    [NUM_CUR];
  logic [NUM_CUR-1:0] chan_bit;
  logic [NUM_CUR-1:0] fb_src;
  logic [NUM_CUR-1:0] res_valid;
  logic [DATA_W-1:0] sinc_q   [NUM_CUR];
  logic [DATA_W-1:0] iir_q    [NUM_CUR];
  logic [ADDR_W-1:0] cfg_off, sinc_off, iir_off;

  assign cfg_off  = reg_addr - A_CUR_CFG_BASE;
  assign sinc_off = reg_addr - A_CUR_SINC_BASE;
  assign iir_off  = reg_addr - A_CUR_IIR_BASE;

  // Only the configuration words take writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CUR; i++)
        cfg_q[i] <= CFG_SAFE;
    end else if (reg_wr && cfg_off < ADDR_W'(NUM_CUR)) begin
      cfg_q[cfg_off[TAG_W-1:0]] <= reg_wdata[CFG_W-1:0];
    end
  end

  // ==========================================================
  // Input selection and filter chains
  assign fb_src[0] = pulse_output_five;
  assign fb_src[1] = pulse_output_six;
  assign fb_src[2] = pulse_output_seven;
  assign fb_src[3] = pulse_output_eight;
  assign fb_src[4] = pulse_output_eight;

  for (genvar c = 0; c < NUM_CUR; c++) begin : g_chan
    assign chan_bit[c] = cfg_q[c][FBSEL_BIT] ? fb_src[c] : sd_bit[c];

    cfs_cur_chan #(
      .DEC_RATIO (DEC_RATIO)
    ) u_chan (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .bit_in      (chan_bit[c]),
      .decay       (cfg_q[c][DECAY_LSB +: DECAY_W]),
      .gain        (cfg_q[c][GAIN_LSB +: GAIN_W]),
      .sinc_q      (sinc_q[c]),
      .iir_q       (iir_q[c]),
      .res_valid_q (res_valid[c])
    );
  end

  // ==========================================================
  // LVDT 4 stage captures
  logic [DATA_W-1:0] lv4_sinc_q, lv4_iir_q, lv4_rms_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lv4_sinc_q <= '0;
      lv4_iir_q  <= '0;
      lv4_rms_q  <= '0;
    end else if (lvdt_four_stage_valid) begin
      lv4_sinc_q <= lvdt_four_decimator_sample;
      lv4_iir_q  <= lvdt_four_highpass_sample;
      lv4_rms_q  <= lvdt_four_rms_sample;
    end
  end

  // ==========================================================
  // LVDT 3/4 averagers over the last 8 or 16 final samples
  logic [DATA_W-1:0] hist_q  [2][AVG_LONG];
  logic [DATA_W-1:0] final_q [2];
  logic [1:0]        fin_vld;
  logic [DATA_W-1:0] fin_smp [2];
  logic [4:0]        avg_len;
  logic [2:0]        avg_log;

  assign fin_vld    = {lvdt_four_final_valid, lvdt_three_final_valid};
  assign fin_smp[0] = lvdt_three_final_sample;
  assign fin_smp[1] = lvdt_four_final_sample;
  assign avg_len = lvdt_pair_average_length ? 5'(AVG_LONG) : 5'(AVG_SHORT);
  assign avg_log = lvdt_pair_average_length ? AVG_LONG_LOG : AVG_SHORT_LOG;

  for (genvar l = 0; l < 2; l++) begin : g_avg
    logic [DATA_W+3:0] sum;

    // Sum of the newest entries in the chosen window
    always_comb begin
      sum = '0;
      for (int k = 0; k < AVG_LONG; k++)
        if (5'(k) < avg_len)
          sum = sum + (DATA_W+4)'(hist_q[l][k]);
    end

    // Shift history and publish the mean
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        for (int k = 0; k < AVG_LONG; k++)
          hist_q[l][k] <= '0;
        final_q[l] <= '0;
      end else begin
        if (fin_vld[l]) begin
          hist_q[l][0] <= fin_smp[l];
          for (int k = 1; k < AVG_LONG; k++)
            hist_q[l][k] <= hist_q[l][k-1];
        end
        final_q[l] <= DATA_W'(sum >> avg_log);
      end
    end
  end

  // ==========================================================
  // Read decode, one cycle latency
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (!reg_rd)
        reg_rdata <= reg_rdata;
      else if (cfg_off < ADDR_W'(NUM_CUR))
        reg_rdata <= {7'h00, cfg_q[cfg_off[TAG_W-1:0]]};
      else if (sinc_off < ADDR_W'(NUM_CUR))
        reg_rdata <= sinc_q[sinc_off[TAG_W-1:0]];
      else if (iir_off < ADDR_W'(NUM_CUR))
        reg_rdata <= iir_q[iir_off[TAG_W-1:0]];
      else if (reg_addr == A_LV3_FINAL)
        reg_rdata <= final_q[0];
      else if (reg_addr == A_LV4_FINAL)
        reg_rdata <= final_q[1];
      else if (reg_addr == A_LV4_SINC)
        reg_rdata <= lv4_sinc_q;
      else if (reg_addr == A_LV4_IIR)
        reg_rdata <= lv4_iir_q;
      else if (reg_addr == A_LV4_RMS)
        reg_rdata <= lv4_rms_q;
      else
        reg_rdata <= '0;
    end
  end

  // ==========================================================
  // Sample stream: pending flags, lowest channel first
  cfs_stream_if #(.W(SMP_W)) push_s ();
  cfs_stream_if #(.W(SMP_W)) pop_s ();

  logic [NUM_CUR-1:0] pend_q, pend_clr;
  logic [TAG_W-1:0]   pick;

  always_comb begin
    pick     = '0;
    pend_clr = '0;
    for (int c = NUM_CUR - 1; c >= 0; c--)
      if (pend_q[c])
        pick = TAG_W'(c);
    if (push_s.ready && pend_q != '0)
      pend_clr[pick] = 1'b1;
  end

  // A new result wins over the clear of the same flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      pend_q <= '0;
    else
      pend_q <= (pend_q & ~pend_clr) | res_valid;
  end

  assign push_s.valid = (pend_q != '0);
  assign push_s.data  = {pick, iir_q[pick]};

  cfs_skid u_skid (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

  assign smp_valid   = pop_s.valid;
  assign pop_s.ready = smp_ready;
  assign smp_data    = pop_s.data[DATA_W-1:0];
  assign smp_chan    = pop_s.data[SMP_W-1 -: TAG_W];

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  cfg_hold_a: assert property (
    !(reg_wr && reg_addr == A_CUR_CFG_BASE) |=> $stable(cfg_q[0]))
    else $error("channel 1 config changed without a write");
  cfg_write_a: assert property (
    reg_wr && reg_addr == A_CUR_CFG_BASE
    |=> cfg_q[0] == $past(reg_wdata[CFG_W-1:0]))
    else $error("channel 1 config did not take the write");
  fb_one_a: assert property (
    cfg_q[0][FBSEL_BIT] |-> chan_bit[0] == pulse_output_five)
    else $error("channel 1 not fed from pulse output 5");
  fb_two_a: assert property (
    !cfg_q[1][FBSEL_BIT] |-> chan_bit[1] == sd_bit[1])
    else $error("channel 2 not fed from its modulator");
  fb_three_a: assert property (
    cfg_q[2][FBSEL_BIT] |-> chan_bit[2] == pulse_output_seven)
    else $error("channel 3 not fed from pulse output 7");
  fb_shared_a: assert property (
    cfg_q[3][FBSEL_BIT] && cfg_q[4][FBSEL_BIT]
    |-> chan_bit[3] == pulse_output_eight && chan_bit[4] == chan_bit[3])
    else $error("channels 4 and 5 differ on shared feedback");
  sinc_ro_a: assert property (
    reg_wr && reg_addr == A_CUR_SINC_BASE && !res_valid[0]
    ##1 !res_valid[0] |-> $stable(sinc_q[0]))
    else $error("result changed by a register write");
  cfg_upper_a: assert property (
    reg_rd && cfg_off < ADDR_W'(NUM_CUR)
    |=> reg_rvalid && reg_rdata[15:9] == 7'h00)
    else $error("config upper bits not zero");
  rms_read_a: assert property (
    reg_rd && reg_addr == A_LV4_RMS |=> reg_rdata == $past(lv4_rms_q))
    else $error("rms result read wrong");
  avg_len_a: assert property (
    avg_len == (lvdt_pair_average_length ? 5'h10 : 5'h08))
    else $error("averager window length wrong");

endmodule

`default_nettype wire

/* File: cfs_src_model.sv */
// Upstream model: modulator bitstreams, pulse feedback and LVDT stages.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`default_nettype none

module cfs_src_model
  import cfs_pkg::*;
(
  input  wire logic               sys_clk,
  output logic      [NUM_CUR-1:0] sd_bit,
  output logic      [3:0]         pwm_fb,
  output logic      [DATA_W-1:0]  lv3_smp,
  output logic                    lv3_vld,
  output logic      [DATA_W-1:0]  lv4_smp,
  output logic                    lv4_vld,
  output logic      [DATA_W-1:0]  lv4_dec,
  output logic      [DATA_W-1:0]  lv4_hp,
  output logic      [DATA_W-1:0]  lv4_rms,
  output logic                    lv4_stg_vld
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle levels
  initial begin
    sd_bit      = '0;
    pwm_fb      = '0;
    lv3_smp     = '0;
    lv3_vld     = 1'b0;
    lv4_smp     = '0;
    lv4_vld     = 1'b0;
    lv4_dec     = '0;
    lv4_hp      = '0;
    lv4_rms     = '0;
    lv4_stg_vld = 1'b0;
  end

  // ==========================================================
  // Stimulus tasks
  // Constant bitstreams and pulse feedback levels
  task automatic set_bits(input logic [4:0] sd, input logic [3:0] pw);
    @(negedge sys_clk);
    sd_bit = sd;
    pwm_fb = pw;
  endtask

  // One final sample per channel; stale value inverted after the strobe
  task automatic push_final(input logic [15:0] a, input logic [15:0] b);
    @(negedge sys_clk);
    lv3_smp = a;
    lv4_smp = b;
    lv3_vld = 1'b1;
    lv4_vld = 1'b1;
    @(negedge sys_clk);
    lv3_vld = 1'b0;
    lv4_vld = 1'b0;
    lv3_smp = ~a;
    lv4_smp = ~b;
  endtask

  // One set of LVDT 4 stage values
  task automatic push_stage(input logic [15:0] d, h, r);
    @(negedge sys_clk);
    lv4_dec     = d;
    lv4_hp      = h;
    lv4_rms     = r;
    lv4_stg_vld = 1'b1;
    @(negedge sys_clk);
    lv4_stg_vld = 1'b0;
    lv4_dec     = ~d;
    lv4_hp      = ~h;
    lv4_rms     = ~r;
  endtask
endmodule

`default_nettype wire

/* File: current_sense_filter_readout_test.sv */
// Self-checking bench for the filter readout block.
// Assumes the upstream model drives the modulator, pulse feedback and LVDT stage inputs; the bench drives the averager length.
`default_nettype none

module current_sense_filter_readout_test
  import cfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEC = 16;

  logic               sys_clk;
  logic               rst_n;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [DATA_W-1:0]  reg_rdata;
  logic               reg_rvalid;
  logic [NUM_CUR-1:0] sd_bit;
  logic [3:0]         pwm_fb;
  logic               lv_len;
  logic [DATA_W-1:0]  lv3_smp;
  logic               lv3_vld;
  logic [DATA_W-1:0]  lv4_smp;
  logic               lv4_vld;
  logic [DATA_W-1:0]  lv4_dec;
  logic [DATA_W-1:0]  lv4_hp;
  logic [DATA_W-1:0]  lv4_rms;
  logic               lv4_stg_vld;
  logic               smp_valid;
  logic               smp_ready;
  logic [DATA_W-1:0]  smp_data;
  logic [TAG_W-1:0]   smp_chan;
  int                 n_fail;
  int                 n_checks;

  // ==========================================================
  // Clock, design and upstream model
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  cfs_filter_readout #(.DEC_RATIO(DEC)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sd_bit(sd_bit),
    .pulse_output_five(pwm_fb[0]), .pulse_output_six(pwm_fb[1]),
    .pulse_output_seven(pwm_fb[2]), .pulse_output_eight(pwm_fb[3]),
    .lvdt_pair_average_length(lv_len),
    .lvdt_three_final_sample(lv3_smp), .lvdt_three_final_valid(lv3_vld),
    .lvdt_four_final_sample(lv4_smp), .lvdt_four_final_valid(lv4_vld),
    .lvdt_four_decimator_sample(lv4_dec),
    .lvdt_four_highpass_sample(lv4_hp), .lvdt_four_rms_sample(lv4_rms),
    .lvdt_four_stage_valid(lv4_stg_vld), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_data(smp_data), .smp_chan(smp_chan));

  cfs_src_model src_u (
    .sys_clk(sys_clk), .sd_bit(sd_bit), .pwm_fb(pwm_fb),
    .lv3_smp(lv3_smp), .lv3_vld(lv3_vld), .lv4_smp(lv4_smp),
    .lv4_vld(lv4_vld), .lv4_dec(lv4_dec), .lv4_hp(lv4_hp),
    .lv4_rms(lv4_rms), .lv4_stg_vld(lv4_stg_vld));

  // ==========================================================
  // Compare, register and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ne(input logic [31:0] a, input logic [31:0] b);
    n_checks++;
    if (a === b) begin
      n_fail++;
      $display("wrong value at %0t: %h equals %h", $time, a, b);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // Answer flag checked half a cycle after the read edge
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(32'(reg_rvalid), 32'h1);
    d = reg_rdata;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Safe values, cleared results, unmapped address
  task automatic t_reset();
    logic [15:0] v;
    int          i;
    for (i = 0; i < 5; i++) begin
      rd(A_CUR_CFG_BASE + 12'(i), v);
      chk(v, 32'h007a);
    end
    rd(A_LV3_FINAL, v);
    chk(v, 32'h0);
    rd(12'h320, v);
    chk(v, 32'h0);
  endtask

  // Field write-back with unimplemented bits dropped
  task automatic t_cfg();
    logic [15:0] v;
    int          i;
    for (i = 0; i < 5; i++) begin
      wr(A_CUR_CFG_BASE + 12'(i), 16'hfe35 + 16'(i));
      rd(A_CUR_CFG_BASE + 12'(i), v);
      chk(v, 32'h0035 + 32'(i));
      wr(A_CUR_CFG_BASE + 12'(i), 16'h01c0);
      rd(A_CUR_CFG_BASE + 12'(i), v);
      chk(v, 32'h01c0);
    end
  endtask

  // Input source select: channels in hi see a high input, others low
  task automatic t_fb(input logic [4:0] sel, sd, hi, input logic [3:0] pw);
    logic [15:0] v [5];
    int          i;
    int          h;
    int          l;
    h = 0;
    l = 0;
    for (i = 0; i < 5; i++) begin
      wr(A_CUR_CFG_BASE + 12'(i), {7'h00, sel[i], 8'h7a});
    end
    src_u.set_bits(sd, pw);
    repeat (8 * DEC) @(negedge sys_clk);
    for (i = 0; i < 5; i++) begin
      rd(A_CUR_SINC_BASE + 12'(i), v[i]);
      if (hi[i]) h = i;
      else l = i;
    end
    for (i = 0; i < 5; i++) begin
      chk(v[i], hi[i] ? 32'h7fff : 32'h8000);
    end
    chk_ne(v[h], v[l]);
  endtask

  // DC removal: decay 0 cancels a steady level, decay 10 keeps most of it
  task automatic t_iir();
    logic [15:0] v;
    wr(A_CUR_CFG_BASE, 16'h0070);
    repeat (3 * DEC) @(negedge sys_clk);
    rd(A_CUR_IIR_BASE, v);
    chk(v, 32'h0);
    rd(A_CUR_IIR_BASE + 12'h001, v);
    chk_ne(v, 32'h0);
    wr(A_CUR_SINC_BASE, 16'h0000);
    rd(A_CUR_SINC_BASE, v);
    chk(v, 32'h7fff);
  endtask

  // LVDT averages, stage values and ignored writes
  task automatic t_lvdt();
    logic [15:0] v;
    int          i;
    for (i = 0; i < 8; i++) src_u.push_final(16'h0100, 16'h0200);
    rd(A_LV3_FINAL, v);
    chk(v, 32'h0100);
    rd(A_LV4_FINAL, v);
    chk(v, 32'h0200);
    lv_len = 1'b1;
    rd(A_LV3_FINAL, v);
    chk(v, 32'h0080);
    rd(A_LV4_FINAL, v);
    chk(v, 32'h0100);
    src_u.push_stage(16'h1234, 16'h5678, 16'h9abc);
    rd(A_LV4_SINC, v);
    chk(v, 32'h1234);
    rd(A_LV4_IIR, v);
    chk(v, 32'h5678);
    rd(A_LV4_RMS, v);
    chk(v, 32'h9abc);
    wr(A_LV4_SINC, 16'hffff);
    wr(A_LV3_FINAL, 16'h0000);
    rd(A_LV4_SINC, v);
    chk(v, 32'h1234);
    rd(A_LV3_FINAL, v);
    chk(v, 32'h0080);
  endtask

  // Consumer stall holds the word, then every channel drains out
  task automatic t_stream();
    logic [18:0] held;
    logic [7:0]  seen;
    @(negedge sys_clk);
    smp_ready = 1'b0;
    repeat (3 * DEC) @(negedge sys_clk);
    held = {smp_chan, smp_data};
    chk(32'(smp_valid), 32'h1);
    repeat (2 * DEC) begin
      @(negedge sys_clk);
      chk({smp_valid, smp_chan, smp_data}, {1'b1, held});
    end
    seen      = '0;
    smp_ready = 1'b1;
    repeat (4 * DEC) begin
      @(negedge sys_clk);
      if (smp_valid === 1'b1) seen[smp_chan] = 1'b1;
    end
    chk(seen, 32'h1f);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    n_fail    = 0;
    n_checks  = 0;
    rst_n     = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    lv_len    = 1'b0;
    smp_ready = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_cfg();
    t_fb(5'h1f, 5'h00, 5'h05, 4'h5);
    t_fb(5'h1f, 5'h00, 5'h1a, 4'ha);
    t_fb(5'h15, 5'h1f, 5'h0a, 4'h0);
    t_fb(5'h0a, 5'h1f, 5'h15, 4'h0);
    t_iir();
    t_lvdt();
    t_stream();
    results();
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    n_fail++;
    results();
  end
endmodule

`default_nettype wire
